/* File: logic/rpc_payload.sv */
// receive payload conditioning stage: registers and data/signaling paths
//
// Notes on behaviour
// R1 - functions act only with master enable set
// R2 - data operations applied in fixed priority order
// R3 - test with direction zero extracts received data
// R4 - mode field; unframed extracts all, ignores selections
// R5 - framed modes extract only selected channels
// R6 - global substitution, else per-channel substitution field
// R7 - A-law milliwatt eight-byte repeating sequence
// R8 - mu-law milliwatt eight-byte repeating sequence
// R9 - signaling force to polarity, T1 SF/ESF/SLC96
// R10 - per-channel msb, even, odd bit inversion
// R11 - test with direction one inserts generated pattern
// R12 - signaling position select in T1 ESF/SLC96
// R13 - snapshot first-frame signaling over multiframe, not DM
// R14 - global signaling trunk code, else per-channel
// R15 - indirect access via address, direction, data, busy
// R16 - indirect table address ranges per mode
// R17 - disabled block passes data and signaling unchanged
// R18 - software waits on busy between accesses
module rpc_payload
	import rpc_pkg::*;
#(
	parameter int NUM_CH = 32
)(
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       ce_i,
	// register port
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	input  wire logic [7:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	output logic      [7:0] reg_rdata_o,
	// framing context
	input  wire logic       e1_mode_i,
	input  wire logic [1:0] t1_format_i,
	// received stream from the framer
	input  wire rpc_rx_t    rx_i,
	input  wire logic [7:0] pattern_i,
	// system side and test side
	output rpc_tx_t         tx_o,
	output rpc_ext_t        ext_o
);

	// ------------------------------------------------------------------
	// parameter check
	// ------------------------------------------------------------------
	if (NUM_CH != 32) begin : g_chk
		$error("rpc_payload: channel index is five bits, NUM_CH must be 32");
	end

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [7:0]             test_cfg;
		logic [7:0]             acc_ctl;
		logic [7:0]             acc_data;
		logic [7:0]             pay_cfg;
		logic [7:0]             ctl_en;
		logic [7:0]             rdata;
		logic [NUM_CH-1:0][3:0] snap;
		rpc_tx_t                tx;
		rpc_ext_t               ext;
	} rpc_main_q_t;

	rpc_main_q_t q;
	rpc_main_q_t d;

	logic       busy;
	logic       rd_done;
	logic [7:0] ind_rdata;
	logic [7:0] ctl_ent;
	logic [7:0] dtrk_ent;
	logic [7:0] strk_ent;
	logic [7:0] mw_a;
	logic [7:0] mw_mu;
	logic       acc_start;

	// ------------------------------------------------------------------
	// submodules
	// ------------------------------------------------------------------
	rpc_ind_regs #(
		.NUM_CH    (NUM_CH)
	) u_ind (
		.clk_i     (clk_i),
		.rst_n_i   (rst_n_i),
		.ce_i      (ce_i),
		.e1_mode_i (e1_mode_i),
		.start_i   (acc_start),
		.addr_i    (reg_wdata_i[6:0]),
		.read_i    (reg_wdata_i[AC_RW]),
		.wdata_i   (q.acc_data),
		.chan_i    (rx_i.chan),
		.busy_o    (busy),
		.rd_done_o (rd_done),
		.rdata_o   (ind_rdata),
		.ctl_o     (ctl_ent),
		.dtrk_o    (dtrk_ent),
		.strk_o    (strk_ent)
	);

	rpc_milliwatt u_mw (
		.clk_i     (clk_i),
		.rst_n_i   (rst_n_i),
		.ce_i      (ce_i),
		.advance_i (rx_i.valid & rx_i.frame_start),
		.alaw_o    (mw_a),
		.mulaw_o   (mw_mu)
	);

	// a new access is taken only while the engine is idle
	assign acc_start = ce_i && reg_wr_i && !busy &&
		(reg_addr_i == REG_ACC_CONTROL); // R15 R18

	// ------------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------------
	function automatic logic [7:0] read_mux(input rpc_main_q_t s,
		input logic [7:0] a, input logic b);
		logic [7:0] v;
		v = '0;
		case (a)
			REG_TEST_CFG:    v = s.test_cfg;
			REG_ACC_STATUS:  v[AS_BUSY] = b;
			REG_ACC_CONTROL: v = s.acc_ctl;
			REG_ACC_DATA:    v = s.acc_data;
			REG_PAYLOAD_CFG: v = s.pay_cfg;
			REG_CTRL_ENABLE: v = s.ctl_en;
			default:         v = '0;
		endcase
		return v;
	endfunction

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		logic       master;
		logic       test_en;
		logic       dir;
		logic [1:0] mode;
		logic       test_sel;
		logic [7:0] mask;
		logic [2:0] sub;
		logic       t1;
		logic [7:0] data;
		logic [3:0] sig;
		master   = 1'b0;
		test_en  = 1'b0;
		dir      = 1'b0;
		mode     = '0;
		test_sel = 1'b0;
		mask     = '0;
		sub      = '0;
		t1       = 1'b0;
		data     = '0;
		sig      = '0;
		d = q;

		// register writes
		if (reg_wr_i) begin
			case (reg_addr_i)
				REG_TEST_CFG:    d.test_cfg = reg_wdata_i;
				REG_ACC_CONTROL: if (!busy) d.acc_ctl = reg_wdata_i;
				REG_ACC_DATA:    d.acc_data = reg_wdata_i;
				REG_PAYLOAD_CFG: d.pay_cfg = reg_wdata_i;
				REG_CTRL_ENABLE: d.ctl_en = reg_wdata_i;
				default:         d.acc_data = d.acc_data;
			endcase
		end
		// read result beats a software write in the same cycle
		if (rd_done) begin
			d.acc_data = ind_rdata; // R15
		end
		if (reg_rd_i) begin
			d.rdata = read_mux(q, reg_addr_i, busy);
		end

		// decode controls
		master  = q.ctl_en[CE_MASTER];
		test_en = q.test_cfg[TC_TEST_EN];
		dir     = q.test_cfg[TC_DIR];
		mode    = q.test_cfg[TC_MODE_LO +: 2];
		t1      = !e1_mode_i;
		test_sel = (mode == MODE_UNFRAMED) ? 1'b1 : strk_ent[ST_TEST]; // R4 R5
		mask    = (mode == MODE_7BIT) ? MASK_7BIT : MASK_ALL;
		sub     = (q.pay_cfg[PC_GSUB_LO +: 3] != SUB_NONE) ?
			q.pay_cfg[PC_GSUB_LO +: 3] : ctl_ent[CC_SUB_LO +: 3]; // R6

		// data path
		data = rx_i.data;
		sig  = rx_i.sig;
		d.ext.valid = 1'b0;
		d.tx.valid  = rx_i.valid;
		if (rx_i.valid && master) begin // R1 R2
			// extraction: a copy goes to the checker
			if (test_en && !dir && test_sel) begin // R3 R4 R5
				d.ext.valid = 1'b1;
				d.ext.data  = data & mask;
			end
			case (sub) // R6
				SUB_TRUNK: data = dtrk_ent;
				SUB_MW_MU: data = mw_mu; // R8
				SUB_MW_A:  data = mw_a; // R7
				default:   data = data;
			endcase
			data = rpc_bits(data, MASK_MSB, ctl_ent[CC_MSB]); // R10
			data = rpc_bits(data, MASK_ODD, ctl_ent[CC_ODD]); // R10
			data = rpc_bits(data, MASK_EVEN, ctl_ent[CC_EVEN]); // R10
			// 7-bit mode leaves the lsb of the channel untouched
			if (test_en && dir && test_sel) begin // R11
				data = (pattern_i & mask) | (data & ~mask);
			end

			// signaling path
			if (q.ctl_en[CE_POS] && t1 &&
				(t1_format_i == FMT_ESF || t1_format_i == FMT_SLC96)) begin
				sig = {sig[3:2], 2'h0}; // R12
			end
			if (q.pay_cfg[PC_SNAP] && !(t1 && t1_format_i == FMT_DM)) begin
				if (rx_i.mf_first) begin // R13
					d.snap[rx_i.chan] = sig;
				end else begin
					sig = q.snap[rx_i.chan]; // R13
				end
			end
			if (q.pay_cfg[PC_GSTRK] || strk_ent[ST_EN]) begin // R14
				sig = strk_ent[ST_CODE_LO +: 4];
			end
			if (q.ctl_en[CE_SIGNALING_FORCE_ENABLE] && t1 && t1_format_i != FMT_DM) begin
				sig = {4{q.ctl_en[CE_POL]}}; // R9
			end
		end
		// disabled: stream passes as received
		if (rx_i.valid) begin // R17
			d.tx.data = data;
			d.tx.sig  = sig;
		end

		if (!ce_i) begin
			d = q;
		end
	end

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q          <= '0;
			q.test_cfg <= REG_RESET_VAL;
			q.ctl_en   <= REG_RESET_VAL;
			q.pay_cfg  <= REG_RESET_VAL;
		end else begin
			q <= d;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign reg_rdata_o = q.rdata;
	assign tx_o        = q.tx;
	assign ext_o       = q.ext;

endmodule // rpc_payload

/* File: logic/rpc_pkg.sv */
// package: constants, field layouts and carriers of the receive payload block
package rpc_pkg;

	// ------------------------------------------------------------------
	// direct register offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] REG_TEST_CFG    = 8'hc7;
	localparam logic [7:0] REG_ACC_STATUS  = 8'hcd;
	localparam logic [7:0] REG_ACC_CONTROL = 8'hce;
	localparam logic [7:0] REG_ACC_DATA    = 8'hcf;
	localparam logic [7:0] REG_PAYLOAD_CFG = 8'hd0;
	localparam logic [7:0] REG_CTRL_ENABLE = 8'hd1;
	localparam logic [7:0] REG_RESET_VAL   = 8'h00;

	// ------------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------------
	// test configuration
	localparam int TC_TEST_EN  = 0;
	localparam int TC_DIR      = 1;
	localparam int TC_MODE_LO  = 2;
	// access status / control
	localparam int AS_BUSY     = 0;
	localparam int AC_RW       = 7;
	// payload configuration
	localparam int PC_GSUB_LO  = 0;
	localparam int PC_SNAP     = 3;
	localparam int PC_GSTRK    = 4;
	// control enable
	localparam int CE_MASTER   = 0;
	localparam int CE_SIGNALING_FORCE_ENABLE   = 1;
	localparam int CE_POL      = 2;
	localparam int CE_POS      = 3;
	// channel control entry
	localparam int CC_SUB_LO   = 0;
	localparam int CC_MSB      = 3;
	localparam int CC_ODD      = 4;
	localparam int CC_EVEN     = 5;
	// signaling trunk entry
	localparam int ST_CODE_LO  = 0;
	localparam int ST_EN       = 4;
	localparam int ST_TEST     = 5;

	// ------------------------------------------------------------------
	// encodings
	// ------------------------------------------------------------------
	localparam logic [1:0] MODE_UNFRAMED = 2'h0;
	localparam logic [1:0] MODE_8BIT     = 2'h1;
	localparam logic [1:0] MODE_7BIT     = 2'h2;
	localparam logic [2:0] SUB_NONE      = 3'h0;
	localparam logic [2:0] SUB_TRUNK     = 3'h1;
	localparam logic [2:0] SUB_MW_MU     = 3'h2;
	localparam logic [2:0] SUB_MW_A      = 3'h3;
	localparam logic [1:0] FMT_SF        = 2'h0;
	localparam logic [1:0] FMT_ESF       = 2'h1;
	localparam logic [1:0] FMT_SLC96     = 2'h2;
	localparam logic [1:0] FMT_DM        = 2'h3;
	localparam logic [7:0] MASK_ALL      = 8'hff;
	localparam logic [7:0] MASK_7BIT     = 8'hfe;
	localparam logic [7:0] MASK_MSB      = 8'h80;
	localparam logic [7:0] MASK_ODD      = 8'haa;
	localparam logic [7:0] MASK_EVEN     = 8'h55;

	// indirect space: bits 6:5 select the table, 4:0 the channel
	localparam logic [1:0] IND_CHAN_CTL  = 2'h0;
	localparam logic [1:0] IND_DTRK      = 2'h1;
	localparam logic [1:0] IND_STRK      = 2'h2;
	localparam logic [4:0] T1_FIRST_CH   = 5'h01;
	localparam logic [4:0] T1_LAST_CH    = 5'h18;
	localparam logic [1:0] IND_BUSY_CYC  = 2'h2;

	// ------------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic       valid;
		logic [4:0] chan;
		logic [7:0] data;
		logic [3:0] sig;
		logic       frame_start;
		logic       mf_first;
	} rpc_rx_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
		logic [3:0] sig;
	} rpc_tx_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} rpc_ext_t;

	typedef enum logic [1:0] {
		IND_IDLE = 2'b01,
		IND_WAIT = 2'b10
	} rpc_ind_state_t;

	// ------------------------------------------------------------------
	// shared decoding
	// ------------------------------------------------------------------
	function automatic logic rpc_ind_addr_ok(input logic [6:0] addr,
		input logic e1);
		logic ok;
		ok = (addr[6:5] != 2'h3);
		if (!e1 && (addr[4:0] < T1_FIRST_CH || addr[4:0] > T1_LAST_CH))
			ok = 1'b0;
		return ok;
	endfunction

	function automatic logic [7:0] rpc_bits(input logic [7:0] v,
		input logic [7:0] m, input logic sel);
		return sel ? (v ^ m) : v;
	endfunction

endpackage : rpc_pkg

/* File: logic/rpc_milliwatt.sv */
// milliwatt byte sequencer: A-law and mu-law tables stepped per frame
module rpc_milliwatt
	import rpc_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       ce_i,
	input  wire logic       advance_i,
	output logic      [7:0] alaw_o,
	output logic      [7:0] mulaw_o
);

	typedef struct packed {
		logic [2:0] idx;
	} rpc_mw_state_t;

	// first listed bit is the msb of each byte
	localparam logic [7:0] ALAW_TAB [8] = '{8'h34, 8'h21, 8'h21, 8'h34,
		8'hb4, 8'ha1, 8'ha1, 8'hb4}; // R7
	localparam logic [7:0] MULAW_TAB [8] = '{8'h1e, 8'h0b, 8'h0b, 8'h1e,
		8'h9e, 8'h8b, 8'h8b, 8'h9e}; // R8

	rpc_mw_state_t q;
	rpc_mw_state_t d;

	always_comb begin
		d = q;
		if (ce_i && advance_i) begin
			d.idx = q.idx + 3'h1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign alaw_o  = ALAW_TAB[q.idx];
	assign mulaw_o = MULAW_TAB[q.idx];

endmodule // rpc_milliwatt

/* File: logic/rpc_ind_regs.sv */
// indirect tables: channel control, data trunk codes, signaling trunk codes
module rpc_ind_regs
	import rpc_pkg::*;
#(
	parameter int NUM_CH = 32
)(
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       ce_i,
	input  wire logic       e1_mode_i,
	input  wire logic       start_i,
	input  wire logic [6:0] addr_i,
	input  wire logic       read_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic [4:0] chan_i,
	output logic            busy_o,
	output logic            rd_done_o,
	output logic      [7:0] rdata_o,
	output logic      [7:0] ctl_o,
	output logic      [7:0] dtrk_o,
	output logic      [7:0] strk_o
);

	typedef struct packed {
		rpc_ind_state_t              st;
		logic [1:0]                  cnt;
		logic [6:0]                  addr;
		logic                        rd;
		logic [7:0]                  wdata;
		logic                        done;
		logic [7:0]                  rdata;
		logic [NUM_CH-1:0][7:0]      ctl;
		logic [NUM_CH-1:0][7:0]      dtrk;
		logic [NUM_CH-1:0][7:0]      strk;
	} rpc_ind_q_t;

	rpc_ind_q_t q;
	rpc_ind_q_t d;

	always_comb begin
		d = q;
		d.done = 1'b0;
		case (q.st)
			IND_IDLE: begin
				if (start_i) begin // R15
					d.st    = IND_WAIT;
					d.cnt   = '0;
					d.addr  = addr_i;
					d.rd    = read_i;
					d.wdata = wdata_i;
				end
			end
			IND_WAIT: begin
				d.cnt = q.cnt + 2'h1;
				if (q.cnt == IND_BUSY_CYC - 2'h1) begin
					d.st   = IND_IDLE;
					d.done = q.rd;
					d.rdata = '0;
					// out-of-range addresses read zero, writes dropped
					if (rpc_ind_addr_ok(q.addr, e1_mode_i)) begin // R16
						case (q.addr[6:5])
							IND_CHAN_CTL: begin
								if (q.rd) d.rdata = q.ctl[q.addr[4:0]];
								else d.ctl[q.addr[4:0]] = q.wdata;
							end
							IND_DTRK: begin
								if (q.rd) d.rdata = q.dtrk[q.addr[4:0]];
								else d.dtrk[q.addr[4:0]] = q.wdata;
							end
							default: begin
								if (q.rd) d.rdata = q.strk[q.addr[4:0]];
								else d.strk[q.addr[4:0]] = q.wdata;
							end
						endcase
					end
				end
			end
			default: begin
				d.st = IND_IDLE;
			end
		endcase
		if (!ce_i) begin
			d = q;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q    <= '0;
			q.st <= IND_IDLE;
		end else begin
			q <= d;
		end
	end

	assign busy_o    = (q.st == IND_WAIT); // R15
	assign rd_done_o = q.done;
	assign rdata_o   = q.rdata;
	assign ctl_o     = q.ctl[chan_i];
	assign dtrk_o    = q.dtrk[chan_i];
	assign strk_o    = q.strk[chan_i];

endmodule // rpc_ind_regs

/* File: tb/rpc_payload_sva.sv */
// checker: port-level relations of the receive payload stage
module rpc_payload_sva
	import rpc_pkg::*;
(
	input wire logic       clk_i,
	input wire logic       rst_n_i,
	input wire logic       ce_i,
	input wire logic       reg_wr_i,
	input wire logic       reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic       e1_mode_i,
	input wire logic [1:0] t1_format_i,
	input wire rpc_rx_t    rx_i,
	input wire logic [7:0] pattern_i,
	input wire rpc_tx_t    tx_o,
	input wire rpc_ext_t   ext_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	// ------------------------------------------------------------------
	// shadow of the control registers, updated like the design's
	// ------------------------------------------------------------------
	logic [7:0] ctl_q;
	logic [7:0] tst_q;
	logic       en;
	logic       xu;
	logic       pu;
	logic       fx;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctl_q <= 8'h00;
			tst_q <= 8'h00;
		end else if (reg_wr_i && ce_i) begin
			if (reg_addr_i == REG_CTRL_ENABLE)
				ctl_q <= reg_wdata_i;
			if (reg_addr_i == REG_TEST_CFG)
				tst_q <= reg_wdata_i;
		end
	end
	assign en = ctl_q[CE_MASTER];
	assign xu = tst_q[TC_TEST_EN] && tst_q[3:2] == MODE_UNFRAMED;
	assign pu = xu && tst_q[TC_DIR];
	assign fx = ctl_q[CE_SIGNALING_FORCE_ENABLE] && !e1_mode_i && t1_format_i != FMT_DM;

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	a_tx_valid_follow: assert property (ce_i |=> tx_o.valid == $past(rx_i.valid))
		else $error("tx valid does not follow rx valid");
	a_freeze_hold: assert property (!ce_i |=> $stable(tx_o) && $stable(ext_o))
		else $error("outputs moved while clock enable low");
	a_off_pass: assert property (ce_i && !en && rx_i.valid |=>
		tx_o.data == $past(rx_i.data) && tx_o.sig == $past(rx_i.sig))
		else $error("disabled block altered the stream");
	a_off_no_ext: assert property (ce_i && !en |=> !ext_o.valid)
		else $error("extraction while disabled");
	a_ext_unframed: assert property (ce_i && en && xu && !tst_q[TC_DIR] && rx_i.valid
		|=> ext_o.valid && ext_o.data == $past(rx_i.data))
		else $error("unframed extraction missed a byte");
	a_pat_unframed: assert property (ce_i && en && pu && rx_i.valid
		|=> tx_o.data == $past(pattern_i))
		else $error("unframed pattern not inserted");
	a_sig_force: assert property (ce_i && en && fx && rx_i.valid
		|=> tx_o.sig == {4{$past(ctl_q[CE_POL])}})
		else $error("signaling not forced");
	a_rdata_hold: assert property (!(reg_rd_i && ce_i) |=> $stable(reg_rdata_o))
		else $error("read data changed without a read");
	a_rd_enable: assert property (ce_i && reg_rd_i && !reg_wr_i
		&& reg_addr_i == REG_CTRL_ENABLE |=> reg_rdata_o[3:0] == ctl_q[3:0])
		else $error("control enable readback wrong");
endmodule // rpc_payload_sva

bind rpc_payload rpc_payload_sva u_sva (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.ce_i(ce_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
	.reg_rdata_o(reg_rdata_o), .e1_mode_i(e1_mode_i),
	.t1_format_i(t1_format_i), .rx_i(rx_i), .pattern_i(pattern_i),
	.tx_o(tx_o), .ext_o(ext_o));

/* File: tb/rpc_framer_model.sv */
// upstream framer model: T1 channel stream 1..24 with frame markers
module rpc_framer_model
	import rpc_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       run_i,
	output rpc_rx_t         rx_o,
	output logic      [7:0] pattern_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] ch;
	logic [7:0] fr;
	always @(negedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ch = 5'h01;
			fr = 8'h00;
			rx_o = '0;
			pattern_o = 8'h00;
		end else if (run_i) begin
			rx_o.valid = 1'b1;
			rx_o.chan = ch;
			rx_o.frame_start = (ch == 5'h01);
			rx_o.mf_first = !fr[0];
			rx_o.data = {fr[2:0], ch};
			rx_o.sig = ch[3:0] ^ fr[3:0];
			pattern_o = ~{ch, fr[2:0]};
			fr = (ch == 5'h18) ? fr + 8'h01 : fr;
			ch = (ch == 5'h18) ? 5'h01 : ch + 5'h01;
		end else begin
			// idle bytes toggle so a stale byte never looks fresh
			rx_o.valid = 1'b0;
			rx_o.data = ~rx_o.data;
			pattern_o = ~pattern_o;
		end
	end
endmodule // rpc_framer_model

/* File: tb/tb_top.sv */
// testbench of the receive payload stage
module tb_top
	import rpc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed { logic [7:0] a; logic [7:0] w; logic [7:0] e; } rpc_reg_t;
	typedef struct packed { logic [7:0] d1; logic [7:0] c7; } rpc_row_t;
	localparam logic [7:0] TRK5 = 8'h3c;
	localparam logic [63:0] MW_A = 64'h34212134b4a1a1b4;
	localparam logic [63:0] MW_MU = 64'h1e0b0b1e9e8b8b9e;
	logic       clk_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1, run = 1'b0;
	logic       reg_wr_i = 1'b0, reg_rd_i = 1'b0, e1_mode_i = 1'b0;
	logic       chk = 1'b0, mw = 1'b0, vq = 1'b0, ok, m;
	logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
	logic [7:0] pattern_i, p_q, rd, d1, c7;
	logic [1:0] t1_format_i = FMT_SF;
	logic [63:0] tbl;
	rpc_rx_t    rx_i, rx_q;
	rpc_tx_t    tx_o, et;
	rpc_ext_t   ext_o;
	logic [7:0] mwq[$];
	int         err_total = 0, checks_done = 0;
	rpc_reg_t   regs[5] = '{'{REG_TEST_CFG, 8'h08, 8'h08},
		'{REG_PAYLOAD_CFG, 8'h18, 8'h18}, '{REG_CTRL_ENABLE, 8'h0e, 8'h0e},
		'{REG_ACC_STATUS, 8'hff, 8'h00}, '{8'h00, 8'h5a, 8'h00}};
	rpc_row_t   rows[10] = '{'{8'h0e, 8'h03}, '{8'h01, 8'h00}, '{8'h07, 8'h00},
		'{8'h03, 8'h00}, '{8'h01, 8'h03}, '{8'h01, 8'h07}, '{8'h01, 8'h01},
		'{8'h01, 8'h0b}, '{8'h01, 8'h09}, '{8'h01, 8'h05}};

	always #2 clk_i = ~clk_i;

	rpc_payload #(.NUM_CH(32)) DUT (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.ce_i(ce_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_rdata_o(reg_rdata_o), .e1_mode_i(e1_mode_i),
		.t1_format_i(t1_format_i), .rx_i(rx_i), .pattern_i(pattern_i),
		.tx_o(tx_o), .ext_o(ext_o));
	rpc_framer_model u_src (.clk_i(clk_i), .rst_n_i(rst_n_i), .run_i(run),
		.rx_o(rx_i), .pattern_o(pattern_i));

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	task automatic check(input logic [7:0] got, exp, input string what);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("Error %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic reg_wr(input logic [7:0] a, d);
		@(negedge clk_i);
		reg_wr_i = 1'b1;
		reg_addr_i = a;
		reg_wdata_i = d;
		@(negedge clk_i);
		reg_wr_i = 1'b0;
	endtask
	task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_i);
		reg_rd_i = 1'b1;
		reg_addr_i = a;
		@(negedge clk_i);
		reg_rd_i = 1'b0;
		d = reg_rdata_o;
	endtask
	// software may not touch the window while the engine is busy
	task automatic wait_idle();
		logic [7:0] s;
		s = 8'h01;
		for (int n = 0; n < 10 && s[AS_BUSY] !== 1'b0; n++)
			reg_rd(REG_ACC_STATUS, s);
		if (s[AS_BUSY] !== 1'b0) begin
			err_total++;
			$display("Error %0t busy never cleared", $time);
			close_out();
		end
	endtask
	task automatic ind_wr(input logic [6:0] a, input logic [7:0] d);
		reg_wr(REG_ACC_DATA, d);
		reg_wr(REG_ACC_CONTROL, {1'b0, a});
		wait_idle();
	endtask
	task automatic ind_rd(input logic [6:0] a, output logic [7:0] d);
		reg_wr(REG_ACC_CONTROL, {1'b1, a});
		wait_idle();
		reg_rd(REG_ACC_DATA, d);
	endtask
	task automatic run_frames(input int n);
		@(negedge clk_i);
		run <= 1'b1;
		repeat (n * 24) @(negedge clk_i);
		run <= 1'b0;
		repeat (2) @(negedge clk_i);
	endtask
	function automatic rpc_tx_t exp_tx(rpc_rx_t r, logic [7:0] p);
		rpc_tx_t t;
		logic [7:0] k;
		k = (c7[3:2] == MODE_7BIT) ? MASK_7BIT : MASK_ALL;
		t = '{valid: 1'b1, data: r.data, sig: r.sig};
		if (d1[CE_MASTER]) begin
			if (r.chan == 5'h05)
				t.data = TRK5 ^ MASK_ODD ^ MASK_MSB;
			if (r.chan == 5'h06)
				t.data = r.data ^ MASK_EVEN;
			if (d1[CE_SIGNALING_FORCE_ENABLE])
				t.sig = {4{d1[CE_POL]}};
			if (c7[TC_TEST_EN] && c7[TC_DIR] && (c7[3:2] == MODE_UNFRAMED || r.chan == 5'h05))
				t.data = (p & k) | (t.data & ~k);
		end
		return t;
	endfunction

	// ------------------------------------------------------------------
	// stream monitor: output of each byte is due one cycle later
	// ------------------------------------------------------------------
	always @(posedge clk_i) begin
		vq <= rx_i.valid && ce_i;
		rx_q <= rx_i;
		p_q <= pattern_i;
	end
	always @(negedge clk_i) begin
		if (chk && vq) begin
			et = exp_tx(rx_q, p_q);
			check(tx_o.data, et.data, "data");
			check({4'h0, tx_o.sig}, {4'h0, et.sig}, "sig");
			check({7'h0, ext_o.valid}, {7'h0, d1[0] && c7[0] && !c7[1] && (c7[3:2] == MODE_UNFRAMED || rx_q.chan == 5'h05)}, "ext");
			if (ext_o.valid)
				check(ext_o.data, rx_q.data & ((c7[3:2] == MODE_7BIT) ?
					MASK_7BIT : MASK_ALL), "ext data");
		end
		if (mw && vq && rx_q.chan == 5'h02)
			mwq.push_back(tx_o.data);
	end

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		repeat (2) @(negedge clk_i);
		rst_n_i = 1'b1;
		foreach (regs[i]) begin
			reg_rd(regs[i].a, rd);
			check(rd, REG_RESET_VAL, "reset value");
			reg_wr(regs[i].a, regs[i].w);
			reg_rd(regs[i].a, rd);
			check(rd, regs[i].e, "readback");
		end
		reg_wr(REG_PAYLOAD_CFG, 8'h00);
		ind_wr(7'h25, TRK5);
		ind_wr(7'h05, 8'h19);
		ind_wr(7'h06, 8'h20);
		ind_wr(7'h45, 8'h20);
		ind_rd(7'h05, rd);
		check(rd, 8'h19, "indirect read");
		ind_wr(7'h00, 8'h5a);
		ind_rd(7'h00, rd);
		check(rd, 8'h00, "out of range");
		foreach (rows[i]) begin
			d1 = rows[i].d1;
			c7 = rows[i].c7;
			reg_wr(REG_CTRL_ENABLE, d1);
			reg_wr(REG_TEST_CFG, c7);
			chk = 1'b1;
			run_frames(2);
			chk = 0;
		end
		// frozen clock enable in mid frame
		c7 = 8'h00;
		reg_wr(REG_TEST_CFG, c7);
		chk = 1'b1;
		run <= 1'b1;
		repeat (30) @(negedge clk_i);
		ce_i = 1'b0;
		repeat (3) @(negedge clk_i);
		ce_i = 1'b1;
		repeat (15) @(negedge clk_i);
		run <= 1'b0;
		repeat (2) @(negedge clk_i);
		chk = 1'b0;
		for (int c = 0; c < 2; c++) begin
			tbl = c ? MW_MU : MW_A;
			reg_wr(REG_PAYLOAD_CFG, c ? {5'h0, SUB_MW_MU} : {5'h0, SUB_MW_A});
			mwq.delete();
			mw = 1'b1;
			run_frames(9);
			mw = 1'b0;
			ok = 1'b0;
			for (int j = 0; j < 8; j++) begin
				m = 1'b1;
				foreach (mwq[k])
					if (mwq[k] !== tbl[63 - 8 * ((j + k) % 8) -: 8])
						m = 1'b0;
				ok = ok | m;
			end
			check({7'h0, ok && mwq.size() == 9}, 8'h01, "milliwatt");
		end
		close_out();
	end
endmodule // tb_top
